/* File: inc/bwe_pkg.sv */
package bwe_pkg;

    // System clock and processor clock periods
    localparam int SYS_PERIOD_NS = 40;
    localparam int CPU_PERIOD_NS = 200;
    localparam int SYS_PER_CPU = CPU_PERIOD_NS / SYS_PERIOD_NS;

    // State counter layout
    localparam int CNT_W = 2;
    localparam int CNT_WAIT_BIT = 1;
    localparam logic [CNT_W-1:0] CNT_CLEAR = 2'h0;
    localparam logic [CNT_W-1:0] CNT_THIRD = 2'h1;
    localparam logic [CNT_W-1:0] CNT_WAIT = 2'h2;
    localparam logic [CNT_W-1:0] CNT_FULL = 2'h3;

    localparam int BYTE_W = 8;
    localparam logic [BYTE_W-1:0] ADDR_RESET = 8'h00;

    localparam logic READY_IDLE = 1'b1;
    localparam logic ENABLE_IDLE = 1'b0;
    localparam logic WR_INHIBIT_N = 1'b1;

    // Address presented to memory and I/O decode
    typedef struct packed {
        logic [BYTE_W-1:0] upper;
        logic [BYTE_W-1:0] low;
    } bwe_addr_s;

endpackage

/* File: core/bwe_edge_det.sv */
`timescale 1ns/10ps
module bwe_edge_det
    import bwe_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);

    logic [W-1:0] prev;

    if (W < 1) begin : g_chk
        $error("bwe_edge_det: W must be at least 1");
    end

    // Previous sample of each level
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prev <= '0;
        end else begin
            prev <= level_in;
        end
    end

    assign rise_out = level_in & ~prev;
    assign fall_out = ~level_in & prev;

endmodule

/* File: core/bwe_wait_enable.sv */
`timescale 1ns/10ps
// Operation
// - Bus cycle is four 200 ns states
// - One wait state added every bus cycle
// - Strobe clears counter until second state
// - Counter 01 at third, 10 at wait
// - Ready samples wait bit on narrowed clock
// - Ready low across second and third state edges
// - Count 11 loads all ones, freezing counter
// - Enable only in second, third, wait states
// - Enable flop takes NAND on inverted clock
// - Active-low enable is the complement
// - Low address byte latched at strobe fall
// - Upper byte unlatched, top bits unused
// - RAM writes inhibited while processor in reset
module bwe_wait_enable
    import bwe_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cpu_clk_in,
    input wire logic src_clk_in,
    input wire logic ale_in,
    input wire logic cpu_reset_n_in,
    input wire logic [BYTE_W-1:0] muxed_low_addr_data_in,
    input wire logic [BYTE_W-1:0] upper_address_byte_in,
    output logic ready_out,
    output logic enable_out,
    output logic enable_n_out,
    output logic ram_wr_en_n_out,
    output bwe_addr_s addr_out
);

    logic [CNT_W-1:0] state_count_bits;
    logic [2:0] levels;
    logic [2:0] rises;
    logic [2:0] falls;
    logic cpu_rise;
    logic narrow_rise;
    logic inv_rise;
    logic sat_nand;
    logic [BYTE_W-1:0] low_addr;

    default clocking cb_sys @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    if (SYS_PER_CPU < 3) begin : g_chk
        $error("bwe_wait_enable: system clock too slow for cpu clock");
    end

    // Processor clock, narrowed clock, strobe
    assign levels = {ale_in, cpu_clk_in & src_clk_in, cpu_clk_in};

    bwe_edge_det #(.W(3)) u_edges (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .level_in(levels),
        .rise_out(rises),
        .fall_out(falls)
    );

    assign cpu_rise = rises[0];
    assign narrow_rise = rises[1];
    assign inv_rise = falls[0];
    assign sat_nand = ~&state_count_bits;

    // State counter
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_count_bits <= CNT_FULL;
        end else if (ale_in) begin
            state_count_bits <= CNT_CLEAR;
        end else if (!sat_nand) begin
            state_count_bits <= CNT_FULL;
        end else if (cpu_rise) begin
            state_count_bits <= state_count_bits + 2'h1;
        end
    end

    // Ready flop
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !cpu_reset_n_in) begin
            ready_out <= READY_IDLE;
        end else if (narrow_rise) begin
            ready_out <= state_count_bits[CNT_WAIT_BIT];
        end
    end

    // Control-bus enable flop
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !cpu_reset_n_in) begin
            enable_out <= ENABLE_IDLE;
            enable_n_out <= ~ENABLE_IDLE;
        end else if (inv_rise) begin
            enable_out <= sat_nand;
            enable_n_out <= ~sat_nand;
        end
    end

    // Low address latch, transparent while strobe high
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            low_addr <= ADDR_RESET;
        end else if (ale_in) begin
            low_addr <= muxed_low_addr_data_in;
        end
    end

    // Address out: upper byte passes straight, top bits never used
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_out <= '0;
        end else begin
            addr_out.low <= ale_in ? muxed_low_addr_data_in : low_addr;
            addr_out.upper <= upper_address_byte_in;
        end
    end

    // RAM write enable
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ram_wr_en_n_out <= WR_INHIBIT_N;
        end else begin
            ram_wr_en_n_out <= ~cpu_reset_n_in;
        end
    end

    // Bus cycle steps seen on the system clock
    sequence s_step;
        cpu_rise && !ale_in && sat_nand;
    endsequence

    sequence s_narrow;
        narrow_rise && cpu_reset_n_in;
    endsequence

    sequence s_wait_req;
        s_narrow ##0 !state_count_bits[CNT_WAIT_BIT];
    endsequence

    sequence s_strobe_end;
        ale_in ##1 !ale_in;
    endsequence

    // Rest of one processor clock with no narrow edge
    sequence s_ready_quiet;
        (cpu_reset_n_in && !narrow_rise) [*4];
    endsequence

    AST_CLEAR: assert property (
        ale_in |=> state_count_bits == CNT_CLEAR)
        else $error("counter not cleared by strobe");

    AST_STROBE_END: assert property (
        s_strobe_end |-> state_count_bits == CNT_CLEAR)
        else $error("counter not clear after strobe");

    AST_STEP_THIRD: assert property (
        s_step ##0 state_count_bits == CNT_CLEAR |=>
        state_count_bits == CNT_THIRD)
        else $error("counter missed 01");

    AST_STEP_WAIT: assert property (
        s_step ##0 state_count_bits == CNT_THIRD |=>
        state_count_bits == CNT_WAIT)
        else $error("counter missed 10");

    AST_STEP_FULL: assert property (
        s_step ##0 state_count_bits == CNT_WAIT |=>
        state_count_bits == CNT_FULL)
        else $error("counter missed 11");

    AST_FREEZE: assert property (
        (state_count_bits == CNT_FULL && !ale_in) [*2] |=>
        state_count_bits == CNT_FULL)
        else $error("saturated counter moved");

    AST_IDLE_RISE: assert property (
        cpu_rise && !ale_in && state_count_bits == CNT_FULL |=>
        state_count_bits == CNT_FULL)
        else $error("idle clock moved counter");

    AST_READY: assert property (
        s_narrow |=> ready_out == $past(state_count_bits[CNT_WAIT_BIT]))
        else $error("ready did not follow wait bit");

    AST_READY_HOLD: assert property (
        cpu_reset_n_in && !narrow_rise |=> $stable(ready_out))
        else $error("ready moved without narrow edge");

    AST_READY_LOW: assert property (
        s_wait_req ##1 s_ready_quiet |-> !ready_out)
        else $error("ready not low across next clock");

    AST_READY_UP: assert property (
        s_narrow ##0 state_count_bits == CNT_WAIT |=> ready_out)
        else $error("ready not released in wait slot");

    AST_ENABLE: assert property (
        inv_rise && cpu_reset_n_in |=> enable_out == $past(sat_nand))
        else $error("enable did not follow nand");

    AST_ENABLE_HOLD: assert property (
        cpu_reset_n_in && !inv_rise |=> $stable(enable_out))
        else $error("enable moved without falling clock");

    AST_ENABLE_ON: assert property (
        inv_rise && cpu_reset_n_in && state_count_bits == CNT_WAIT |=>
        enable_out)
        else $error("enable off in wait slot");

    AST_ENABLE_OFF: assert property (
        inv_rise && cpu_reset_n_in && state_count_bits == CNT_FULL |=>
        !enable_out)
        else $error("enable on after counter saturated");

    AST_ENABLE_N: assert property (
        ##1 enable_n_out == !enable_out)
        else $error("enable complement mismatch");

    AST_WR_INHIBIT: assert property (
        !cpu_reset_n_in |=> ram_wr_en_n_out)
        else $error("RAM write not inhibited in reset");

    AST_WR_ALLOW: assert property (
        cpu_reset_n_in |=> !ram_wr_en_n_out)
        else $error("RAM write blocked while running");

    AST_RST_FORCE: assert property (
        !cpu_reset_n_in |=> ready_out && !enable_out)
        else $error("reset did not force ready and enable");

    AST_LATCH_HOLD: assert property (
        !ale_in ##1 !ale_in |=> $stable(addr_out.low))
        else $error("latched address changed");

    AST_LATCH_CAPTURE: assert property (
        $fell(ale_in) |-> addr_out.low == $past(muxed_low_addr_data_in))
        else $error("low address not captured at strobe fall");

    AST_UPPER_PASS: assert property (
        ##1 addr_out.upper == $past(upper_address_byte_in))
        else $error("upper address byte not passed");

endmodule

/* File: tb/bwe_cpu_model.sv */
`timescale 1ns/10ps
module bwe_cpu_model
    import bwe_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] idle_in,
    input wire bwe_addr_s addr_in,
    output logic cpu_clk_out,
    output logic src_clk_out,
    output logic ale_out,
    output bwe_addr_s bus_out,
    output logic [2:0] slot_out,
    output logic [2:0] ph_out
);
    // Five system cycles per state; slots above 4 are idle
    always_ff @(negedge clk_in) begin
        if (!rst_n_in) begin
            ph_out <= 3'h0;
            slot_out <= 3'h5;
        end else if (ph_out != 3'h4) begin
            ph_out <= ph_out + 3'h1;
        end else begin
            ph_out <= 3'h0;
            slot_out <= (slot_out >= 3'h4 + idle_in) ? 3'h0 : slot_out + 3'h1;
        end
    end
    assign cpu_clk_out = ph_out < 3'h2;
    assign src_clk_out = ph_out == 3'h1;
    // Strobe late in first state, dropped just after second state starts
    assign ale_out = (slot_out == 3'h0 && ph_out > 3'h2) ||
        (slot_out == 3'h1 && ph_out == 3'h0);
    assign bus_out.upper = addr_in.upper;
    // Address in first state, other data once the bus turns round
    assign bus_out.low = (slot_out == 3'h0 || ale_out) ?
        addr_in.low : ~addr_in.low;
endmodule

/* File: tb/bwe_wait_enable_tb.sv */
`timescale 1ns/10ps
module bwe_wait_enable_tb;
    import bwe_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cpu_rst_n = 1'b1;
    logic [2:0] idle = 3'h0;
    bwe_addr_s addr = 16'h0000;
    bwe_addr_s bus;
    bwe_addr_s addr_q;
    logic cclk, sclk, ale, rdy, en, en_n, wr_n;
    logic [2:0] slot, ph;
    int num_errors = 0;
    int samples_checked = 0;
    always #20 clk_in = ~clk_in;
    bwe_cpu_model i_bwe_cpu_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .idle_in(idle), .addr_in(addr), .cpu_clk_out(cclk),
        .src_clk_out(sclk), .ale_out(ale), .bus_out(bus),
        .slot_out(slot), .ph_out(ph));
    bwe_wait_enable i_bwe_wait_enable (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .cpu_clk_in(cclk), .src_clk_in(sclk),
        .ale_in(ale), .cpu_reset_n_in(cpu_rst_n),
        .muxed_low_addr_data_in(bus.low),
        .upper_address_byte_in(bus.upper), .ready_out(rdy),
        .enable_out(en), .enable_n_out(en_n),
        .ram_wr_en_n_out(wr_n), .addr_out(addr_q));
    task automatic finish_test();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Stop just after the edge in the last phase of slot s
    task automatic wait_slot(input logic [2:0] s);
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge clk_in);
            #1;
            if (slot === s && ph === 3'h4) break;
        end
        if (n == 400) chk("slot reached", 16'h0001, 16'h0000);
    endtask
    task automatic test_cycle(input logic [2:0] gap, input bwe_addr_s a);
        logic [4:0] rdy_t;
        logic [4:0] en_t;
        int s;
        rdy_t = 5'h19;
        en_t = 5'h0E;
        wait_slot(3'h4);
        idle = gap;
        @(negedge clk_in);
        addr = a;
        for (s = 0; s < 5; s++) begin
            wait_slot(3'(s));
            chk("ready", rdy_t[s], rdy);
            chk("enable", en_t[s], en);
            chk("enable_n", !en_t[s], en_n);
        end
        chk("addr", a, addr_q);
        $display("cycle test gap %0d done", gap);
    endtask
    task automatic test_cpu_reset();
        wait_slot(3'h0);
        @(negedge clk_in);
        cpu_rst_n = 1'b0;
        wait_slot(3'h2);
        chk("wr_n held", 1'b1, wr_n);
        chk("ready held", 1'b1, rdy);
        chk("enable held", 1'b0, en);
        @(negedge clk_in);
        cpu_rst_n = 1'b1;
        wait_slot(3'h3);
        chk("wr_n run", 1'b0, wr_n);
        $display("cpu reset test done");
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in <= 1'b1;
        test_cycle(3'h0, 16'hA5C3);
        test_cycle(3'h0, 16'h5A3C);
        test_cycle(3'h3, 16'hF00F);
        test_cpu_reset();
        test_cycle(3'h1, 16'h0FF0);
        finish_test();
    end
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end
endmodule
